// [rtl/tocc_map.vh]
/*
 Register map and field layout for the timer channel 2 output-compare control.
 Assumes inclusion by tocc_top.v and by the self-checking bench.
*/
`ifndef TOCC_MAP_VH
`define TOCC_MAP_VH
`define TOCC_CTRL_ADDR    8'h18
`define TOCC_COMPARE_ADDR 8'h38
`define TOCC_STATUS_ADDR  8'h40
`define TOCC_CTRL_RESET   16'h0000
`define TOCC_CLEAR_BIT    15
`define TOCC_MODE_HI      14
`define TOCC_MODE_LO      12
`define TOCC_PRELOAD_BIT  11
`define TOCC_FAST_BIT     10
`define TOCC_DIR_HI       9
`define TOCC_DIR_LO       8
`define TOCC_DIR_OUTPUT   2'h0
`define TOCC_MODE_FREEZE  3'h0
`define TOCC_MODE_SET     3'h1
`define TOCC_MODE_CLR     3'h2
`define TOCC_MODE_TOGGLE  3'h3
`define TOCC_MODE_LOW     3'h4
`define TOCC_MODE_HIGH    3'h5
`define TOCC_MODE_PWM1    3'h6
`define TOCC_MODE_PWM2    3'h7
`define TOCC_RESP_OKAY    2'h0
`define TOCC_RESP_SLVERR  2'h2
`endif

// [rtl/tocc_top.v]
/*
 Channel 2 output-compare control of a general-purpose timer, with an
 AXI4-Lite register slave. Registers, by byte address:
   0x18 control: bit 15 clear enable, 14:12 output mode, 11 compare
        preload enable, 10 stored without effect, 9:8 direction,
        7:0 stored without effect
   0x38 compare value: the preload copy while preload is on,
        otherwise the active shadow copy
   0x40 status, read only: bit 0 main output, 1 complementary
        output, 2 compare direction, 3 synchronised trigger,
        4 reference
 Unmapped addresses answer SLVERR, read zero and change nothing.
 Write response one cycle after the later of address and data;
 read data one cycle after the address. Reference and outputs move
 one edge after their inputs; the trigger adds two sync edges.
 Limitation: the direction field is writable at any time, and PWM
 without preload is only meant for one-pulse operation.
 Assumes the core counter, its direction, the update event and the
 polarity bits come from timer logic on aclk; the filtered external
 trigger comes from outside and is synchronised here.
*/
`timescale 1ns/1ps
`include "tocc_map.vh"
module tocc_top #(
    parameter CNT_W = 16
) (
    input  wire             aclk,
    input  wire             aresetn,
    input  wire [7:0]       s_axi_awaddr,
    input  wire             s_axi_awvalid,
    output reg              s_axi_awready,
    input  wire [31:0]      s_axi_wdata,
    input  wire [3:0]       s_axi_wstrb,
    input  wire             s_axi_wvalid,
    output reg              s_axi_wready,
    output reg  [1:0]       s_axi_bresp,
    output reg              s_axi_bvalid,
    input  wire             s_axi_bready,
    input  wire [7:0]       s_axi_araddr,
    input  wire             s_axi_arvalid,
    output reg              s_axi_arready,
    output reg  [31:0]      s_axi_rdata,
    output reg  [1:0]       s_axi_rresp,
    output reg              s_axi_rvalid,
    input  wire             s_axi_rready,
    input  wire [CNT_W-1:0] core_count,
    input  wire             count_down,
    input  wire             update_event,
    input  wire             ch2_output_polarity,
    input  wire             ch2_complementary_polarity,
    input  wire             filtered_external_trigger,
    output reg              ch2_output_reference,
    output reg              ch2_main_output,
    output reg              ch2_complementary_output,
    output reg              ch2_compare_mode_active
);

    reg  [15:0]      ctrl;
    reg  [CNT_W-1:0] compare_preload;
    reg  [CNT_W-1:0] compare_shadow;
    reg              trig_meta;
    reg              trig_sync;
    reg              aw_held;
    reg              w_held;
    reg  [7:0]       aw_addr;
    reg  [31:0]      w_data;
    reg  [3:0]       w_strb;
    reg              next_ref;
    reg  [31:0]      next_rdata;
    reg  [1:0]       next_rresp;

    wire ch2_reference_clear_enable = ctrl[`TOCC_CLEAR_BIT];
    wire [2:0] ch2_output_mode_field = ctrl[`TOCC_MODE_HI:`TOCC_MODE_LO];
    wire ch2_compare_preload_enable = ctrl[`TOCC_PRELOAD_BIT];
    wire [1:0] ch2_direction_select = ctrl[`TOCC_DIR_HI:`TOCC_DIR_LO];
    wire is_output = (ch2_direction_select == `TOCC_DIR_OUTPUT);
    wire match = (core_count == compare_shadow);
    wire above = (core_count > compare_shadow);
    wire aw_ok = aw_held || s_axi_awvalid;
    wire w_ok  = w_held || s_axi_wvalid;
    wire do_write = aw_ok && w_ok && !s_axi_bvalid;
    wire [7:0]  wr_addr = aw_held ? aw_addr : s_axi_awaddr;
    wire [31:0] wr_data = w_held ? w_data : s_axi_wdata;
    wire [3:0]  wr_strb = w_held ? w_strb : s_axi_wstrb;

    // Byte-lane merge shared by every writable register
    function [31:0] merge;
        input [31:0] old;
        input [31:0] data;
        input [3:0]  strb;
        integer i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) begin
                    merge[i*8 +: 8] = data[i*8 +: 8];
                end
            end
        end
    endfunction

    // Address decode, shared by the write and read paths except addr_status, which only reads use
    function addr_ctrl;
        input [7:0] a;
        begin
            addr_ctrl = (a == `TOCC_CTRL_ADDR);
        end
    endfunction

    function addr_compare;
        input [7:0] a;
        begin
            addr_compare = (a == `TOCC_COMPARE_ADDR);
        end
    endfunction

    function addr_status;
        input [7:0] a;
        begin
            addr_status = (a == `TOCC_STATUS_ADDR);
        end
    endfunction

    // Mode 2 is mode 1 inverted; counting down inverts both
    function pwm_level;
        input gt;
        input down;
        input second;
        begin
            pwm_level = (down ^ second) ? gt : !gt;
        end
    endfunction

    // Polarity bit set inverts the active level of that output
    function pol_apply;
        input level;
        input invert;
        begin
            pol_apply = level ^ invert;
        end
    endfunction

    // Write target, from the held or the live address
    wire        wr_hit_ctrl = addr_ctrl(wr_addr);
    wire        wr_hit_cmp  = addr_compare(wr_addr);
    wire        wr_hit_any  = wr_hit_ctrl || wr_hit_cmp;

    // Status word; reading it has no side effect
    wire [31:0] status_word = {27'h0, ch2_output_reference, trig_sync,
                               ch2_compare_mode_active, ch2_complementary_output,
                               ch2_main_output};

    wire [31:0] ctrl_merged = merge({16'h0000, ctrl}, wr_data, wr_strb);
    wire [31:0] cmp_visible = ch2_compare_preload_enable ?
                              {{(32-CNT_W){1'b0}}, compare_preload} :
                              {{(32-CNT_W){1'b0}}, compare_shadow};
    wire [31:0] cmp_merged = merge(cmp_visible, wr_data, wr_strb);

    // Trigger comes from a pin, so two stages before use
    always @(posedge aclk) begin
        if (!aresetn) begin
            trig_meta <= 1'b0;
            trig_sync <= 1'b0;
        end else begin
            trig_meta <= filtered_external_trigger;
            trig_sync <= trig_meta;
        end
    end

    // Write channel: address and data taken in either order
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `TOCC_RESP_OKAY;
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= 8'h00;
            w_data        <= 32'h00000000;
            w_strb        <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held       <= 1'b0;
                w_held        <= 1'b0;
                s_axi_awready <= 1'b0;
                s_axi_wready  <= 1'b0;
                s_axi_bvalid  <= 1'b1;
                if (wr_hit_any) begin
                    s_axi_bresp <= `TOCC_RESP_OKAY;
                end else begin
                    s_axi_bresp <= `TOCC_RESP_SLVERR;
                end
            end else begin
                if (s_axi_awvalid && s_axi_awready) begin
                    aw_held       <= 1'b1;
                    s_axi_awready <= 1'b0;
                end
                if (s_axi_wvalid && s_axi_wready) begin
                    w_held       <= 1'b1;
                    s_axi_wready <= 1'b0;
                end
                if (s_axi_bvalid && s_axi_bready) begin
                    s_axi_bvalid  <= 1'b0;
                    s_axi_awready <= 1'b1;
                    s_axi_wready  <= 1'b1;
                end
            end
        end
    end

    // Registers: control word and the two compare copies
    always @(posedge aclk) begin
        if (!aresetn) begin
            ctrl            <= `TOCC_CTRL_RESET;
            compare_preload <= {CNT_W{1'b0}};
            compare_shadow  <= {CNT_W{1'b0}};
        end else begin
            if (do_write && wr_hit_ctrl) begin
                ctrl <= ctrl_merged[15:0];
            end
            if (ch2_compare_preload_enable) begin
                if (do_write && wr_hit_cmp) begin
                    compare_preload <= cmp_merged[CNT_W-1:0];
                end
                if (update_event) begin
                    compare_shadow <= compare_preload;
                end
            end else if (do_write && wr_hit_cmp) begin
                // Both copies follow so a later preload switch starts coherent
                compare_shadow  <= cmp_merged[CNT_W-1:0];
                compare_preload <= cmp_merged[CNT_W-1:0];
            end
        end
    end

    // Read channel decode
    always @* begin
        next_rdata = 32'h00000000;
        next_rresp = `TOCC_RESP_OKAY;
        if (addr_ctrl(s_axi_araddr)) begin
            next_rdata = {16'h0000, ctrl};
        end else if (addr_compare(s_axi_araddr)) begin
            next_rdata = cmp_visible;
        end else if (addr_status(s_axi_araddr)) begin
            next_rdata = status_word;
        end else begin
            next_rresp = `TOCC_RESP_SLVERR;
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `TOCC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= next_rdata;
            s_axi_rresp   <= next_rresp;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // Reference level from the mode field
    always @* begin
        next_ref = ch2_output_reference;
        case (ch2_output_mode_field)
            `TOCC_MODE_FREEZE: next_ref = ch2_output_reference;
            `TOCC_MODE_SET: begin
                if (match) begin
                    next_ref = 1'b1;
                end
            end
            `TOCC_MODE_CLR: begin
                if (match) begin
                    next_ref = 1'b0;
                end
            end
            `TOCC_MODE_TOGGLE: begin
                if (match) begin
                    next_ref = !ch2_output_reference;
                end
            end
            `TOCC_MODE_LOW:  next_ref = 1'b0;
            `TOCC_MODE_HIGH: next_ref = 1'b1;
            `TOCC_MODE_PWM1: next_ref = pwm_level(above, count_down, 1'b0);
            `TOCC_MODE_PWM2: next_ref = pwm_level(above, count_down, 1'b1);
            default:         next_ref = ch2_output_reference;
        endcase
        // Capture direction leaves the reference idle
        if (!is_output) begin
            next_ref = 1'b0;
        end
        if (ch2_reference_clear_enable && trig_sync) begin
            next_ref = 1'b0;
        end
    end

    // Outputs move with the reference, so no extra lag at the pins
    always @(posedge aclk) begin
        if (!aresetn) begin
            ch2_output_reference     <= 1'b0;
            ch2_main_output          <= 1'b0;
            ch2_complementary_output <= 1'b0;
            ch2_compare_mode_active  <= 1'b0;
        end else begin
            ch2_output_reference     <= next_ref;
            ch2_main_output          <= pol_apply(next_ref, ch2_output_polarity);
            ch2_complementary_output <= pol_apply(!next_ref,
                                                  ch2_complementary_polarity);
            ch2_compare_mode_active  <= is_output;
        end
    end

endmodule

// [sim/tocc_properties.sv]
/* Port checker for tocc_top.
   Assumes one aclk domain and synchronous active-low aresetn. */
`timescale 1ns/1ps
module tocc_checker (
    input wire        aclk,
    input wire        aresetn,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire        ch2_output_polarity,
    input wire        ch2_complementary_polarity,
    input wire        ch2_output_reference,
    input wire        ch2_main_output,
    input wire        ch2_complementary_output,
    input wire        ch2_compare_mode_active
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Pair relation holds whichever reference edge the outputs use
    chk_pol_pair: assert property ($past(aresetn) |->
        (ch2_main_output ^ ch2_complementary_output)
        == !($past(ch2_output_polarity) ^ $past(ch2_complementary_polarity)))
        else $error("pair");
    // Polarity is sampled with the reference level it was applied to
    chk_main_level: assert property ($past(aresetn) |->
        ch2_main_output == (ch2_output_reference ^ $past(ch2_output_polarity)))
        else $error("main level");
    chk_compl_level: assert property ($past(aresetn) |->
        ch2_complementary_output
        == (!ch2_output_reference ^ $past(ch2_complementary_polarity)))
        else $error("compl level");
    chk_capture_quiet: assert property (
        !ch2_compare_mode_active |-> !ch2_output_reference) else $error("capture ref");
    chk_b_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("b hold");
    chk_r_hold: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("r hold");
    chk_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("aw ready");
    chk_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("ar ready");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("r late");
    chk_write_answer: assert property (s_axi_awvalid && s_axi_awready
        && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid) else $error("b late");
endmodule
bind tocc_top tocc_checker tocc_checker_inst (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .ch2_output_polarity,
    .ch2_complementary_polarity, .ch2_output_reference, .ch2_main_output,
    .ch2_complementary_output, .ch2_compare_mode_active);

// [sim/tb_tocc_top.sv]
/* Self-checking bench for tocc_top.
   Assumes the map header and the port checker are compiled alongside. */
`timescale 1ns/1ps
`include "tocc_map.vh"
module tb_tocc_top;
    reg         aclk = 1'b0, aresetn = 1'b0;
    reg  [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    reg  [31:0] s_axi_wdata = 32'h0;
    reg  [3:0]  s_axi_wstrb = 4'hF;
    reg         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    reg         s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, count_down = 1'b0;
    reg         update_event = 1'b0, filtered_external_trigger = 1'b0;
    reg         ch2_output_polarity = 1'b0, ch2_complementary_polarity = 1'b0;
    reg  [15:0] core_count = 16'h0;
    wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0]  s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire        ch2_output_reference, ch2_main_output, ch2_complementary_output;
    wire        ch2_compare_mode_active;
    integer     failures = 0, check_count = 0, i;
    reg  [31:0] rd;
    reg  [1:0]  rs;
    reg  [11:0] e;
    // Per entry: mode, {down, expected}, count; compare sits at 5
    localparam [179:0] TBL = 180'h513213205103115405005606614636624716704726734;
    always #10 aclk = ~aclk;
    tocc_top tocc_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .core_count, .count_down, .update_event,
        .ch2_output_polarity, .ch2_complementary_polarity, .filtered_external_trigger,
        .ch2_output_reference, .ch2_main_output, .ch2_complementary_output,
        .ch2_compare_mode_active);
    task chk(input string what, input [31:0] exp, input [31:0] got);
        begin
            check_count = check_count + 1;
            if (got !== exp) begin
                failures = failures + 1;
                $display("MISMATCH %0s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    task close_out;
        begin
            $display("Checks %0d mismatches %0d", check_count, failures);
            if (failures == 0 && check_count > 0) $display("Finished cleanly");
            else $display("Finished with errors");
            $finish;
        end
    endtask
    task wt(input integer k);
        begin
            repeat (k) @(posedge aclk);
            #1;
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        begin
            @(posedge aclk);
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
            do begin
                @(posedge aclk);
                if (s_axi_awready) s_axi_awvalid <= 1'b0;
                if (s_axi_wready) s_axi_wvalid <= 1'b0;
            end while (!s_axi_bvalid);
            rs = s_axi_bresp;
            s_axi_bready <= 1'b0;
        end
    endtask
    task rdr(input [7:0] a);
        begin
            @(posedge aclk);
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
            do begin
                @(posedge aclk);
                if (s_axi_arready) s_axi_arvalid <= 1'b0;
            end while (!s_axi_rvalid);
            rd = s_axi_rdata;
            rs = s_axi_rresp;
            s_axi_rready <= 1'b0;
        end
    endtask
    task ctl(input [2:0] m, input clr, input pre);
        begin
            wr(`TOCC_CTRL_ADDR, {16'h0000, clr, m, pre, 3'h0, 8'h00});
            chk("ctrl resp", `TOCC_RESP_OKAY, rs);
            wt(3);
        end
    endtask
    task cnt_to(input [15:0] c, input dn);
        begin
            @(posedge aclk);
            core_count <= c;
            count_down <= dn;
            wt(3);
        end
    endtask
    task pulse_update;
        begin
            @(posedge aclk);
            update_event <= 1'b1;
            @(posedge aclk);
            update_event <= 1'b0;
        end
    endtask
    task step(input integer k);
        begin
            e = TBL[(14 - k) * 12 +: 12];
            cnt_to({12'h000, e[3:0]}, e[5]);
            ctl(e[10:8], 1'b0, 1'b1);
        end
    endtask
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        rdr(`TOCC_CTRL_ADDR);
        chk("ctrl reset", `TOCC_CTRL_RESET, rd);
        rdr(8'h3C);
        chk("unmapped resp", `TOCC_RESP_SLVERR, rs);
        chk("unmapped data", 32'h0, rd);
        wr(8'h3C, 32'h0000FFFF);
        chk("unmapped wr resp", `TOCC_RESP_SLVERR, rs);
        wr(`TOCC_CTRL_ADDR, 32'h0000FFFF);
        rdr(`TOCC_CTRL_ADDR);
        chk("ctrl rw", 32'h0000FFFF, rd);
        // Count above compare would light PWM2 if direction were ignored
        cnt_to(16'h0001, 1'b0);
        chk("dir active", 32'h0, ch2_compare_mode_active);
        chk("dir ref", 32'h0, ch2_output_reference);
        $display("register test done");
        // PWM only with preload on, so the shadow is loaded by update
        ctl(3'h0, 1'b0, 1'b1);
        wr(`TOCC_COMPARE_ADDR, 32'h5);
        pulse_update;
        for (i = 0; i < 7; i = i + 1) begin
            step(i);
            chk("mode ref", e[4], ch2_output_reference);
        end
        for (i = 7; i < 15; i = i + 1) begin
            step(i);
            chk("pwm ref", e[4], ch2_output_reference);
        end
        chk("out active", 32'h1, ch2_compare_mode_active);
        ctl(3'h3, 1'b0, 1'b1);
        for (i = 0; i < 2; i = i + 1) begin
            @(posedge aclk);
            core_count <= 16'h0005;
            @(posedge aclk);
            core_count <= 16'h0006;
            wt(3);
            chk("toggle ref", i % 2, ch2_output_reference);
        end
        $display("mode test done");
        for (i = 0; i < 2; i = i + 1) begin
            ctl(3'h5, i == 0, 1'b1);
            @(posedge aclk);
            filtered_external_trigger <= 1'b1;
            wt(5);
            chk("clear ref", i, ch2_output_reference);
            @(posedge aclk);
            filtered_external_trigger <= 1'b0;
            wt(5);
            chk("unclear ref", 32'h1, ch2_output_reference);
        end
        for (i = 0; i < 2; i = i + 1) begin
            @(posedge aclk);
            ch2_output_polarity <= i % 2;
            ch2_complementary_polarity <= i % 2;
            wt(3);
            chk("main out", 1 - i, ch2_main_output);
            chk("compl out", i, ch2_complementary_output);
        end
        // Reference high, both polarities set, compare direction
        rdr(`TOCC_STATUS_ADDR);
        chk("status", 32'h00000016, rd);
        $display("clear and polarity test done");
        ctl(3'h4, 1'b0, 1'b1);
        wr(`TOCC_COMPARE_ADDR, 32'h9);
        rdr(`TOCC_COMPARE_ADDR);
        chk("preload read", 32'h9, rd);
        cnt_to(16'h0009, 1'b0);
        ctl(3'h1, 1'b0, 1'b1);
        chk("before update", 32'h0, ch2_output_reference);
        pulse_update;
        wt(3);
        chk("after update", 32'h1, ch2_output_reference);
        ctl(3'h4, 1'b0, 1'b0);
        cnt_to(16'h000B, 1'b0);
        wr(`TOCC_COMPARE_ADDR, 32'hB);
        ctl(3'h1, 1'b0, 1'b0);
        chk("direct ref", 32'h1, ch2_output_reference);
        $display("preload test done");
        close_out;
    end
    initial begin
        #200000;
        failures = failures + 1;
        close_out;
    end
endmodule
